/* hw/ussc_pkg.sv */
// Operation
// - device acts as full-speed function; this block serves its suspend handling.
// - suspend signalling detected on the bus, once configured and with no bus reset, enters the suspend state.
// - entering suspend asserts both suspend indicators, high-true and low-true.
// - after device reset both indicators stay asserted until configuration completes.
// - resume detected or generated, bus reset, or device reset leaves suspend.
// - leaving suspend by resume or bus reset deasserts both suspend indicators; device reset keeps them asserted.
// - while suspended, selected pins take stored level and push-pull or open-drain mode.
// - one indicator is high when asserted, its companion low; always complementary.
package ussc_pkg;
    localparam int          PIN_COUNT   = 16;
    localparam logic [1:0]  ST_UNCONF   = 2'b00;
    localparam logic        IND_ON      = 1'b1;

    typedef enum logic [1:0] {
        USSC_UNCONF  = 2'b00,
        USSC_ACTIVE  = 2'b01,
        USSC_SUSPEND = 2'b11
    } ussc_state_t;

    typedef struct packed {
        logic [PIN_COUNT-1:0] sel;
        logic [PIN_COUNT-1:0] level;
        logic [PIN_COUNT-1:0] push_pull;
    } ussc_cfg_t;

    typedef struct packed {
        logic [PIN_COUNT-1:0] out;
        logic [PIN_COUNT-1:0] oe;
    } ussc_pins_t;
endpackage : ussc_pkg

/* hw/ussc_pin_mux.sv */
`timescale 1ns/1ps
module ussc_pin_mux (
    input  wire logic               ref_clk_i,
    input  wire logic               reset_n_i,
    input  wire logic               suspended_i,
    input  wire ussc_pkg::ussc_cfg_t  cfg_i,
    input  wire ussc_pkg::ussc_pins_t normal_i,
    output ussc_pkg::ussc_pins_t    pins_o
);
    import ussc_pkg::*;

    ussc_pins_t next_pins;
    ussc_pins_t susp_pins;
    logic [PIN_COUNT-1:0] use_susp;

    // open-drain drives only the low level, push-pull drives both
    assign use_susp      = cfg_i.sel & {PIN_COUNT{suspended_i}};
    assign susp_pins.out = cfg_i.level;
    assign susp_pins.oe  = cfg_i.push_pull | ~cfg_i.level;
    assign next_pins.out = (use_susp & susp_pins.out) | (~use_susp & normal_i.out);
    assign next_pins.oe  = (use_susp & susp_pins.oe) | (~use_susp & normal_i.oe);

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            pins_o <= '0;
        end else begin
            pins_o <= next_pins;
        end
    end

    susp_level_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        suspended_i |=> ((pins_o.out & $past(cfg_i.sel)) == $past(cfg_i.sel & cfg_i.level)))
        else $error("suspend level not applied");
    normal_back_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        !suspended_i |=> (pins_o == $past(normal_i)))
        else $error("normal pins not restored");
endmodule : ussc_pin_mux

/* hw/ussc_top.sv */
`timescale 1ns/1ps
module ussc_top (
    input  wire logic                 ref_clk_i,
    input  wire logic                 reset_n_i,
    input  wire logic                 bus_suspend_i,
    input  wire logic                 bus_resume_i,
    input  wire logic                 local_wake_i,
    input  wire logic                 bus_reset_i,
    input  wire logic                 configured_i,
    input  wire ussc_pkg::ussc_cfg_t  cfg_i,
    input  wire ussc_pkg::ussc_pins_t normal_i,
    output logic                      suspend_o,
    output logic                      suspend_n_o,
    output ussc_pkg::ussc_pins_t      pins_o
);
    import ussc_pkg::*;

    ussc_state_t state;
    ussc_state_t next_state;
    logic        wake;
    logic        next_ind;
    logic        next_susp;

    ////////////////////////////////////////////////////////////////////////////
    // state
    assign wake = bus_resume_i | local_wake_i | bus_reset_i;

    always_comb begin
        next_state = state;
        unique case (state)
            USSC_UNCONF: begin
                if (configured_i) begin
                    next_state = USSC_ACTIVE;
                end
            end
            USSC_ACTIVE: begin
                if (bus_reset_i) begin
                    next_state = USSC_ACTIVE;
                end else if (bus_suspend_i) begin
                    next_state = USSC_SUSPEND;
                end
            end
            USSC_SUSPEND: begin
                if (wake) begin
                    next_state = USSC_ACTIVE;
                end
            end
            default: begin
                next_state = USSC_UNCONF;
            end
        endcase
    end

    assign next_susp = (next_state == USSC_SUSPEND);
    assign next_ind  = (next_state != USSC_ACTIVE);

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            state       <= USSC_UNCONF;
            suspend_o   <= IND_ON;
            suspend_n_o <= ~IND_ON;
        end else begin
            state       <= next_state;
            suspend_o   <= next_ind;
            suspend_n_o <= ~next_ind;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pins during suspend, serving the function's gpio datapath
    ussc_pin_mux u_mux (
        .ref_clk_i   (ref_clk_i),
        .reset_n_i   (reset_n_i),
        .suspended_i (next_susp),
        .cfg_i       (cfg_i),
        .normal_i    (normal_i),
        .pins_o      (pins_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // elaboration check
    if (PIN_COUNT < 1) begin : g_pin_count
        $error("pin count must be at least one");
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    enter_susp_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (state == USSC_ACTIVE && bus_suspend_i && !bus_reset_i) |=> (state == USSC_SUSPEND))
        else $error("suspend not entered");

    susp_stay_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (state == USSC_SUSPEND && !bus_resume_i && !local_wake_i && !bus_reset_i)
        |=> (state == USSC_SUSPEND))
        else $error("suspend left without wake");

    ind_on_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (state == USSC_SUSPEND) |-> (suspend_o && !suspend_n_o))
        else $error("indicators not asserted in suspend");

    entry_ind_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (state == USSC_ACTIVE && bus_suspend_i && !bus_reset_i) |=> (suspend_o && !suspend_n_o))
        else $error("indicators not raised on suspend entry");

    ind_rise_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        $rose(suspend_o) |-> (state != USSC_ACTIVE))
        else $error("indicator rose while active");

    ind_state_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        suspend_o == (state != USSC_ACTIVE))
        else $error("indicator does not follow state");

    unconf_hold_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (state == USSC_UNCONF && !configured_i) |=> (state == USSC_UNCONF && suspend_o))
        else $error("left unconfigured early");

    unconf_ind_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (state == USSC_UNCONF) |-> (suspend_o && !suspend_n_o))
        else $error("indicators off before configuration");

    early_susp_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (state == USSC_UNCONF) |=> (state != USSC_SUSPEND))
        else $error("suspend entered before configuration");

    unconf_exit_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (state == USSC_UNCONF && configured_i)
        |=> (state == USSC_ACTIVE && !suspend_o && suspend_n_o))
        else $error("configuration did not release indicators");

    config_ignore_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (state != USSC_UNCONF && configured_i) |=> (state != USSC_UNCONF))
        else $error("configuration returned to unconfigured");

    reset_ind_a: assert property (
        @(posedge ref_clk_i)
        !reset_n_i |=> (suspend_o && state == USSC_UNCONF))
        else $error("reset did not assert indicator");

    wake_exit_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (state == USSC_SUSPEND && (bus_resume_i || local_wake_i || bus_reset_i))
        |=> (state == USSC_ACTIVE))
        else $error("suspend not left on wake");

    reset_holds_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (state == USSC_ACTIVE && bus_reset_i) |=> (state == USSC_ACTIVE))
        else $error("suspend entered during bus reset");

    susp_reset_a: assert property (
        @(posedge ref_clk_i)
        (state == USSC_SUSPEND && !reset_n_i) |=> (state == USSC_UNCONF))
        else $error("device reset did not leave suspend");

    ind_off_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        $fell(suspend_o) |-> ($past(state) != USSC_ACTIVE && state == USSC_ACTIVE))
        else $error("indicator fell without exit");

    active_off_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (state == USSC_ACTIVE) |-> (!suspend_o && suspend_n_o))
        else $error("indicator on while active");

    resume_ind_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (state == USSC_SUSPEND && bus_resume_i) |=> (!suspend_o && suspend_n_o))
        else $error("indicators kept after bus resume");

    local_wake_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (state == USSC_SUSPEND && local_wake_i) |=> (!suspend_o && suspend_n_o))
        else $error("indicators kept after local wake");

    active_stay_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (state == USSC_ACTIVE && !bus_suspend_i) |=> (state == USSC_ACTIVE && !suspend_o))
        else $error("active state left without suspend");

    susp_pins_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (state == USSC_SUSPEND)
        |-> ((pins_o.out & $past(cfg_i.sel)) == $past(cfg_i.sel & cfg_i.level)))
        else $error("stored level missing in suspend");

    susp_drive_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (state == USSC_SUSPEND)
        |-> ((pins_o.oe & $past(cfg_i.sel))
            == $past(cfg_i.sel & (cfg_i.push_pull | ~cfg_i.level))))
        else $error("stored drive mode missing in suspend");

    complement_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        suspend_o != suspend_n_o)
        else $error("indicators not complementary");

    comp_reset_a: assert property (
        @(posedge ref_clk_i)
        !reset_n_i |=> (suspend_o && !suspend_n_o))
        else $error("indicators not complementary after reset");

    susp_n_low_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (state != USSC_ACTIVE) |-> !suspend_n_o)
        else $error("low-true indicator not asserted");

    awake_pins_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (state != USSC_SUSPEND && $past(reset_n_i)) |-> (pins_o == $past(normal_i)))
        else $error("normal pins not driven outside suspend");

    exit_pins_a: assert property (
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (state == USSC_SUSPEND && (bus_resume_i || local_wake_i || bus_reset_i))
        |=> (pins_o == $past(normal_i)))
        else $error("pins not restored on suspend exit");
endmodule : ussc_top

/* bench/ussc_host_model.sv */
`timescale 1ns/1ps
// host side: turns a bench command code into bus signalling levels
// code 5: bus reset begins while the suspend detector still reports suspend
module ussc_host_model (
    input  wire logic [2:0] cmd_i,
    output logic            suspend_o,
    output logic            resume_o,
    output logic            bus_reset_o,
    output logic            configured_o
);
    assign suspend_o    = (cmd_i == 3'h1) || (cmd_i == 3'h5);
    assign resume_o     = (cmd_i == 3'h2);
    assign bus_reset_o  = (cmd_i == 3'h3) || (cmd_i == 3'h5);
    assign configured_o = (cmd_i == 3'h4);
endmodule : ussc_host_model

/* bench/ussc_top_bench.sv */
`timescale 1ns/1ps
module ussc_top_bench;
    import ussc_pkg::*;
    logic ref_clk_i = 1'b0, reset_n_i = 1'b0, wake = 1'b0, sus, res, brst, conf, s_o, s_n_o;
    logic [2:0] cmd = 3'h0;
    int bad_count = 0, cmp_count = 0;
    ussc_cfg_t  cfg = '{16'hA5A5, 16'h0F0F, 16'h3C3C};
    ussc_pins_t nrm = '{16'h1234, 16'hF0F0};
    ussc_pins_t pins, exp_sp;
    ussc_host_model host (.cmd_i(cmd), .suspend_o(sus), .resume_o(res), .bus_reset_o(brst),
        .configured_o(conf));
    ussc_top dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .bus_suspend_i(sus),
        .bus_resume_i(res), .local_wake_i(wake), .bus_reset_i(brst), .configured_i(conf),
        .cfg_i(cfg), .normal_i(nrm), .suspend_o(s_o), .suspend_n_o(s_n_o), .pins_o(pins));
    initial begin
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    task automatic chk_ind(input logic s);
        cmp_count++;
        if (s_o !== s || s_n_o !== ~s) begin
            bad_count++;
            $display("BAD %0t indicators %b/%b", $time, s_o, s_n_o);
        end
    endtask : chk_ind
    task automatic chk_pins(input ussc_pins_t p);
        cmp_count++;
        if (pins !== p) begin
            bad_count++;
            $display("BAD %0t pins %h expected %h", $time, pins, p);
        end
    endtask : chk_pins
    task automatic step(input logic [2:0] c, input logic w);
        @(posedge ref_clk_i);
        cmd  <= c;
        wake <= w;
        @(posedge ref_clk_i);
        cmd  <= 3'h0;
        wake <= 1'b0;
        #1;
    endtask : step
    task automatic do_reset;
        @(posedge ref_clk_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        #1;
    endtask : do_reset
    task automatic test_power_up;
        do_reset;
        chk_ind(1'b1);
        step(3'h1, 1'b0);
        chk_ind(1'b1);
        step(3'h4, 1'b0);
        chk_ind(1'b0);
        chk_pins(nrm);
    endtask : test_power_up
    task automatic test_suspend_exit(input logic [2:0] c, input logic w);
        step(3'h1, 1'b0);
        chk_ind(1'b1);
        chk_pins(exp_sp);
        step(c, w);
        chk_ind(1'b0);
        chk_pins(nrm);
    endtask : test_suspend_exit
    task automatic test_refused;
        step(3'h5, 1'b0);
        chk_ind(1'b0);
        chk_pins(nrm);
        step(3'h2, 1'b1);
        chk_ind(1'b0);
        step(3'h4, 1'b0);
        chk_ind(1'b0);
    endtask : test_refused
    task automatic test_reset_exit;
        step(3'h1, 1'b0);
        chk_ind(1'b1);
        do_reset;
        chk_ind(1'b1);
        step(3'h4, 1'b0);
        chk_ind(1'b0);
        chk_pins(nrm);
    endtask : test_reset_exit
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        exp_sp.out = (cfg.sel & cfg.level) | (~cfg.sel & nrm.out);
        exp_sp.oe  = (cfg.sel & (cfg.push_pull | ~cfg.level)) | (~cfg.sel & nrm.oe);
        test_power_up();
        test_suspend_exit(3'h2, 1'b0);
        test_suspend_exit(3'h0, 1'b1);
        test_suspend_exit(3'h3, 1'b0);
        test_refused();
        test_reset_exit();
        print_verdict();
    end
    initial begin
        #20000;
        bad_count++;
        print_verdict();
    end
endmodule : ussc_top_bench
